// ==== verilog/ipsm_defs.vh ====
// Constants for the input pin select map: register offsets, field layout,
// reset values. Assumes inclusion by the route and top design files of the block.
// Overview of operation
// - Map has 37 registers; 21 input, 16 output
// - Map writes ignored while remap lock set
// - Map 0: ext irq1 selector bits 13-8
// - Map 1: irq3 in 13-8, irq2 in 5-0
// - Map 2: ext irq4 selector bits 5-0
// - Map 3: timer3 clk 13-8, timer2 5-0
// - Map 4: timer5 clk 13-8, timer4 5-0
// - Map 7: capture2 13-8, capture1 5-0
// - Map 8: capture4 13-8, capture3 5-0
// - Map 9: capture6 13-8, capture5 5-0
// - Map 10: capture8 13-8, capture7 5-0
// - Map 11: fault B 13-8, fault A 5-0
// - Map 15: capture9 selector bits 13-8
// - Map 17: uart3 receive selector 13-8
// - Map 18: uart1 cts 13-8, receive 5-0
// - Unimplemented bits read zero, ignore writes
// - Selector bits read/write, reset to ones
// - Selector above 43 gives no input
// - Reset selector ties peripheral input low
`ifndef IPSM_DEFS_VH
`define IPSM_DEFS_VH

// ***************************************************************
// Register indices (byte address is four times the index)
// ***************************************************************
`define IPSM_IDX_MAP0 5'd0
`define IPSM_IDX_MAP1 5'd1
`define IPSM_IDX_MAP2 5'd2
`define IPSM_IDX_MAP3 5'd3
`define IPSM_IDX_MAP4 5'd4
`define IPSM_IDX_MAP7 5'd7
`define IPSM_IDX_MAP8 5'd8
`define IPSM_IDX_MAP9 5'd9
`define IPSM_IDX_MAP10 5'd10
`define IPSM_IDX_MAP11 5'd11
`define IPSM_IDX_MAP15 5'd15
`define IPSM_IDX_MAP17 5'd17
`define IPSM_IDX_MAP18 5'd18
`define IPSM_IDX_STATUS 5'd31

// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define IPSM_SEL_W 6
`define IPSM_HI_LSB 8
`define IPSM_LO_LSB 0
`define IPSM_SEL_RESET 6'h3f
`define IPSM_MAX_PIN 6'h2b
`define IPSM_NUM_PINS 44
`define IPSM_NUM_SEL 26
`define IPSM_NUM_IN_REGS 21
`define IPSM_NUM_OUT_REGS 16

`endif

// ==== verilog/ipsm_sync.v ====
// Two flip-flop synchroniser for the remappable pad inputs.
// Assumes pads are asynchronous to ref_clk.
`timescale 1ns/1ps
module ipsm_sync #(
	parameter W = 44
) (
	input wire ref_clk, // System clock
	input wire nrst, // Async reset, active low
	input wire [W-1:0] d, // Asynchronous inputs
	output reg [W-1:0] q // Synchronised outputs
);
	reg [W-1:0] meta_q;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ==== verilog/ipsm_route.v ====
// Routes one synchronised pad to one peripheral input by a 6-bit selector.
// Assumes the pad vector is already in the ref_clk domain.
`timescale 1ns/1ps
`include "ipsm_defs.vh"
module ipsm_route (
	input wire [`IPSM_NUM_PINS-1:0] pads, // Synchronised pad levels
	input wire [`IPSM_SEL_W-1:0] sel, // Pin selector
	output reg y // Routed level
);
	always @* begin
		// Invalid selectors, the reset value among them, give a grounded input
		if (sel > `IPSM_MAX_PIN) begin
			y = 1'b0;
		end else begin
			y = pads[sel];
		end
	end
endmodule

// ==== verilog/ipsm_top.v ====
// Input side of the peripheral pin select matrix with an APB slave.
// Assumes APB master on ref_clk, pads asynchronous, lock bit from outside.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ipsm_defs.vh"
module ipsm_top (
	input wire ref_clk, // System clock, 100 MHz
	input wire nrst, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error
	input wire remap_lock_bit, // Lock from oscillator control register
	input wire [`IPSM_NUM_PINS-1:0] remappable_io_pin, // Pad input levels
	output reg [3:0] ext_irq_in, // External interrupts 4..1
	output reg [3:0] timer_clk_in, // Timer 5..2 clocks
	output reg [8:0] capture_in, // Input captures 9..1
	output reg [1:0] compare_fault_in, // Fault B, A
	output reg uart1_rx_in, // UART1 receive
	output reg uart1_cts_in, // UART1 clear to send
	output reg uart3_rx_in // UART3 receive
);
	// ***************************************************************
	// Selector storage
	// ***************************************************************
	// Order: irq1..4, tmr2..5, cap1..9, faultA, faultB, u3rx, u1rx, u1cts
	localparam S_IRQ = 0;
	localparam S_TMR = 4;
	localparam S_CAP = 8;
	localparam S_FLT = 17;
	localparam S_U3RX = 19;
	localparam S_U1RX = 20;
	localparam S_U1CTS = 21;
	localparam NSEL = 22;

	localparam ST_IDLE = 1'b0;
	localparam ST_ACC = 1'b1;

	reg [`IPSM_SEL_W-1:0] sel_q [0:NSEL-1];
	reg state_q;
	reg lock_m_q;
	reg lock_q;
	wire [`IPSM_NUM_PINS-1:0] pad_s;
	wire [NSEL-1:0] route_y;
	wire [4:0] idx;
	reg [15:0] rd_val;
	reg hit;
	integer i;

	assign idx = paddr[6:2];

	// Slot of the high field of a register, or NSEL if none
	function [4:0] hi_slot;
		input [4:0] r;
		begin
			case (r)
				`IPSM_IDX_MAP0: hi_slot = 5'd0;
				`IPSM_IDX_MAP1: hi_slot = 5'd2;
				`IPSM_IDX_MAP3: hi_slot = 5'd5;
				`IPSM_IDX_MAP4: hi_slot = 5'd7;
				`IPSM_IDX_MAP7: hi_slot = 5'd9;
				`IPSM_IDX_MAP8: hi_slot = 5'd11;
				`IPSM_IDX_MAP9: hi_slot = 5'd13;
				`IPSM_IDX_MAP10: hi_slot = 5'd15;
				`IPSM_IDX_MAP11: hi_slot = 5'd18;
				`IPSM_IDX_MAP15: hi_slot = 5'd16;
				`IPSM_IDX_MAP17: hi_slot = 5'd19;
				`IPSM_IDX_MAP18: hi_slot = 5'd21;
				default: hi_slot = 5'd22;
			endcase
		end
	endfunction

	// Slot of the low field of a register, or NSEL if none
	function [4:0] lo_slot;
		input [4:0] r;
		begin
			case (r)
				`IPSM_IDX_MAP1: lo_slot = 5'd1;
				`IPSM_IDX_MAP2: lo_slot = 5'd3;
				`IPSM_IDX_MAP3: lo_slot = 5'd4;
				`IPSM_IDX_MAP4: lo_slot = 5'd6;
				`IPSM_IDX_MAP7: lo_slot = 5'd8;
				`IPSM_IDX_MAP8: lo_slot = 5'd10;
				`IPSM_IDX_MAP9: lo_slot = 5'd12;
				`IPSM_IDX_MAP10: lo_slot = 5'd14;
				`IPSM_IDX_MAP11: lo_slot = 5'd17;
				`IPSM_IDX_MAP18: lo_slot = 5'd20;
				default: lo_slot = 5'd22;
			endcase
		end
	endfunction

	function is_map;
		input [4:0] r;
		begin
			is_map = (hi_slot(r) != 5'd22) || (lo_slot(r) != 5'd22);
		end
	endfunction

	// ***************************************************************
	// Pad and lock synchronisers
	// ***************************************************************
	ipsm_sync #(
		.W(`IPSM_NUM_PINS)
	) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d(remappable_io_pin),
		.q(pad_s)
	);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lock_m_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			lock_m_q <= remap_lock_bit;
			lock_q <= lock_m_q;
		end
	end

	// ***************************************************************
	// Routing
	// ***************************************************************
	// Named views of the selector slots
	wire [`IPSM_SEL_W-1:0] ext_irq1_pin_sel = sel_q[S_IRQ];
	wire [`IPSM_SEL_W-1:0] ext_irq2_pin_sel = sel_q[S_IRQ+1];
	wire [`IPSM_SEL_W-1:0] ext_irq3_pin_sel = sel_q[S_IRQ+2];
	wire [`IPSM_SEL_W-1:0] ext_irq4_pin_sel = sel_q[S_IRQ+3];
	wire [`IPSM_SEL_W-1:0] timer2_clk_pin_sel = sel_q[S_TMR];
	wire [`IPSM_SEL_W-1:0] timer3_clk_pin_sel = sel_q[S_TMR+1];
	wire [`IPSM_SEL_W-1:0] timer4_clk_pin_sel = sel_q[S_TMR+2];
	wire [`IPSM_SEL_W-1:0] timer5_clk_pin_sel = sel_q[S_TMR+3];
	wire [`IPSM_SEL_W-1:0] capture1_pin_sel = sel_q[S_CAP];
	wire [`IPSM_SEL_W-1:0] capture2_pin_sel = sel_q[S_CAP+1];
	wire [`IPSM_SEL_W-1:0] capture3_pin_sel = sel_q[S_CAP+2];
	wire [`IPSM_SEL_W-1:0] capture4_pin_sel = sel_q[S_CAP+3];
	wire [`IPSM_SEL_W-1:0] capture5_pin_sel = sel_q[S_CAP+4];
	wire [`IPSM_SEL_W-1:0] capture6_pin_sel = sel_q[S_CAP+5];
	wire [`IPSM_SEL_W-1:0] capture7_pin_sel = sel_q[S_CAP+6];
	wire [`IPSM_SEL_W-1:0] capture8_pin_sel = sel_q[S_CAP+7];
	wire [`IPSM_SEL_W-1:0] capture9_pin_sel = sel_q[S_CAP+8];
	wire [`IPSM_SEL_W-1:0] compare_fault_a_pin_sel = sel_q[S_FLT];
	wire [`IPSM_SEL_W-1:0] compare_fault_b_pin_sel = sel_q[S_FLT+1];
	wire [`IPSM_SEL_W-1:0] uart3_receive_pin_sel = sel_q[S_U3RX];
	wire [`IPSM_SEL_W-1:0] uart1_receive_pin_sel = sel_q[S_U1RX];
	wire [`IPSM_SEL_W-1:0] uart1_cts_pin_sel = sel_q[S_U1CTS];

	// External interrupts 1..4
	ipsm_route u_irq1 (
		.pads(pad_s),
		.sel(ext_irq1_pin_sel),
		.y(route_y[S_IRQ])
	);
	ipsm_route u_irq2 (
		.pads(pad_s),
		.sel(ext_irq2_pin_sel),
		.y(route_y[S_IRQ+1])
	);
	ipsm_route u_irq3 (
		.pads(pad_s),
		.sel(ext_irq3_pin_sel),
		.y(route_y[S_IRQ+2])
	);
	ipsm_route u_irq4 (
		.pads(pad_s),
		.sel(ext_irq4_pin_sel),
		.y(route_y[S_IRQ+3])
	);

	// Timer external clocks 2..5
	ipsm_route u_tmr2 (
		.pads(pad_s),
		.sel(timer2_clk_pin_sel),
		.y(route_y[S_TMR])
	);
	ipsm_route u_tmr3 (
		.pads(pad_s),
		.sel(timer3_clk_pin_sel),
		.y(route_y[S_TMR+1])
	);
	ipsm_route u_tmr4 (
		.pads(pad_s),
		.sel(timer4_clk_pin_sel),
		.y(route_y[S_TMR+2])
	);
	ipsm_route u_tmr5 (
		.pads(pad_s),
		.sel(timer5_clk_pin_sel),
		.y(route_y[S_TMR+3])
	);

	// Input captures 1..9
	ipsm_route u_cap1 (
		.pads(pad_s),
		.sel(capture1_pin_sel),
		.y(route_y[S_CAP])
	);
	ipsm_route u_cap2 (
		.pads(pad_s),
		.sel(capture2_pin_sel),
		.y(route_y[S_CAP+1])
	);
	ipsm_route u_cap3 (
		.pads(pad_s),
		.sel(capture3_pin_sel),
		.y(route_y[S_CAP+2])
	);
	ipsm_route u_cap4 (
		.pads(pad_s),
		.sel(capture4_pin_sel),
		.y(route_y[S_CAP+3])
	);
	ipsm_route u_cap5 (
		.pads(pad_s),
		.sel(capture5_pin_sel),
		.y(route_y[S_CAP+4])
	);
	ipsm_route u_cap6 (
		.pads(pad_s),
		.sel(capture6_pin_sel),
		.y(route_y[S_CAP+5])
	);
	ipsm_route u_cap7 (
		.pads(pad_s),
		.sel(capture7_pin_sel),
		.y(route_y[S_CAP+6])
	);
	ipsm_route u_cap8 (
		.pads(pad_s),
		.sel(capture8_pin_sel),
		.y(route_y[S_CAP+7])
	);
	ipsm_route u_cap9 (
		.pads(pad_s),
		.sel(capture9_pin_sel),
		.y(route_y[S_CAP+8])
	);

	// Compare fault inputs A and B
	ipsm_route u_flta (
		.pads(pad_s),
		.sel(compare_fault_a_pin_sel),
		.y(route_y[S_FLT])
	);
	ipsm_route u_fltb (
		.pads(pad_s),
		.sel(compare_fault_b_pin_sel),
		.y(route_y[S_FLT+1])
	);

	// Serial receive and clear to send
	ipsm_route u_u3rx (
		.pads(pad_s),
		.sel(uart3_receive_pin_sel),
		.y(route_y[S_U3RX])
	);
	ipsm_route u_u1rx (
		.pads(pad_s),
		.sel(uart1_receive_pin_sel),
		.y(route_y[S_U1RX])
	);
	ipsm_route u_u1cts (
		.pads(pad_s),
		.sel(uart1_cts_pin_sel),
		.y(route_y[S_U1CTS])
	);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_irq_in <= 4'h0;
			timer_clk_in <= 4'h0;
			capture_in <= 9'h000;
			compare_fault_in <= 2'h0;
			uart1_rx_in <= 1'b0;
			uart1_cts_in <= 1'b0;
			uart3_rx_in <= 1'b0;
		end else begin
			ext_irq_in <= route_y[S_IRQ+3:S_IRQ];
			timer_clk_in <= route_y[S_TMR+3:S_TMR];
			capture_in <= route_y[S_CAP+8:S_CAP];
			compare_fault_in <= route_y[S_FLT+1:S_FLT];
			uart1_rx_in <= route_y[S_U1RX];
			uart1_cts_in <= route_y[S_U1CTS];
			uart3_rx_in <= route_y[S_U3RX];
		end
	end

	// ***************************************************************
	// Read decode
	// ***************************************************************
	always @* begin
		rd_val = 16'h0000;
		hit = 1'b1;
		if (idx == `IPSM_IDX_STATUS) begin
			rd_val = {15'h0000, lock_q};
		end else if (is_map(idx)) begin
			if (hi_slot(idx) != 5'd22) begin
				rd_val[13:8] = sel_q[hi_slot(idx)];
			end
			if (lo_slot(idx) != 5'd22) begin
				rd_val[5:0] = sel_q[lo_slot(idx)];
			end
		end else begin
			hit = 1'b0;
		end
	end

	// ***************************************************************
	// APB slave: one wait state, answer in the second access cycle
	// ***************************************************************
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			for (i = 0; i < NSEL; i = i + 1) begin
				sel_q[i] <= `IPSM_SEL_RESET;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					if (psel && penable) begin
						state_q <= ST_ACC;
						pready <= 1'b1;
						pslverr <= ~hit | (pwrite & (idx == `IPSM_IDX_STATUS));
						prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_val};
					end
				end
				ST_ACC: begin
					state_q <= ST_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
					// Locked writes complete on the bus but store nothing
					if (pwrite && !lock_q && hi_slot(idx) != 5'd22) begin
						sel_q[hi_slot(idx)] <= pwdata[13:8];
					end
					if (pwrite && !lock_q && lo_slot(idx) != 5'd22) begin
						sel_q[lo_slot(idx)] <= pwdata[5:0];
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== dv/ipsm_checker.sv ====
// Port checker for the input pin select map.
// Assumes it is bound onto ipsm_top; one clock domain.
`timescale 1ns/1ps
module ipsm_checker (
	input wire ref_clk, // Clock
	input wire nrst, // Reset
	input wire psel, // Select
	input wire penable, // Enable
	input wire pwrite, // Direction
	input wire [7:0] paddr, // Address
	input wire [31:0] pwdata, // Write data
	input wire [31:0] prdata, // Read data
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire remap_lock_bit, // Lock
	input wire [43:0] remappable_io_pin, // Pads
	input wire [3:0] ext_irq_in, // Irq
	input wire [3:0] timer_clk_in, // Timers
	input wire [8:0] capture_in, // Captures
	input wire [1:0] compare_fault_in, // Faults
	input wire uart1_rx_in, // Rx1
	input wire uart1_cts_in, // Cts1
	input wire uart3_rx_in // Rx3
);
// ****
// Properties
// ****
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
wire [21:0] outs = {ext_irq_in, timer_clk_in, capture_in, compare_fault_in,
	uart1_rx_in, uart1_cts_in, uart3_rx_in};
wire mapd = paddr[6:2] inside {0, 1, 2, 3, 4, 7, 8, 9, 10, 11, 15, 17, 18};
wire unm = !mapd && paddr[6:2] != 5'h1f;
wire rsvd_clr = prdata[31:14] == 0 && prdata[7:6] == 0;
sequence start_s; psel && $rose(penable); endsequence
sequence done_s; psel && penable && pready; endsequence
ready_pulse_a: assert property (pready |=> !pready)
	else $error("ready longer than one cycle");
ready_lat_a: assert property (start_s |=> done_s)
	else $error("ready not one cycle after access");
err_ready_a: assert property (pslverr |-> done_s)
	else $error("error outside completion");
unmapped_err_a: assert property (done_s and unm |-> pslverr && prdata == 0)
	else $error("unmapped access not refused");
locked_ok_a: assert property (done_s and mapd |-> !pslverr)
	else $error("mapped access refused");
rsvd_zero_a: assert property (done_s and !pslverr |-> rsvd_clr)
	else $error("reserved bits not zero");
reset_tie_a: assert property (!$past(nrst) |-> outs == 0)
	else $error("input not tied low after reset");
quiet_pads_a: assert property ((remappable_io_pin == 0) [*3] |=> outs == 0)
	else $error("input high with all pads low");
endmodule
bind ipsm_top ipsm_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .remap_lock_bit(remap_lock_bit),
	.remappable_io_pin(remappable_io_pin), .ext_irq_in(ext_irq_in),
	.timer_clk_in(timer_clk_in), .capture_in(capture_in),
	.compare_fault_in(compare_fault_in), .uart1_rx_in(uart1_rx_in),
	.uart1_cts_in(uart1_cts_in), .uart3_rx_in(uart3_rx_in));

// ==== dv/ipsm_pad_model.sv ====
// Pad array model: drives the remappable pins from a level pattern.
// Assumes the pattern is set by the bench; pads change after an edge.
`timescale 1ns/1ps
module ipsm_pad_model (
	input wire ref_clk, // Clock
	input wire [43:0] pat, // Wanted pad levels
	output reg [43:0] pads // Pad levels
);
initial pads = 44'h0;
always @(posedge ref_clk) begin
	pads <= pat;
end
endmodule

// ==== dv/tb_top.sv ====
// Testbench for the input pin select map.
// Assumes ipsm_top with the checker bound and the pad model beside it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
reg ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, lock = 0;
reg [7:0] paddr = 0;
reg [31:0] pwdata = 0;
reg [43:0] pat = 0;
wire [31:0] prdata;
wire pready, pslverr;
wire [43:0] pads;
wire [22:0] outs;
int err_total = 0, cmp_count = 0;
reg [31:0] r;
reg e;
byte ix[13] = '{0, 1, 2, 3, 4, 7, 8, 9, 10, 11, 15, 17, 18};
reg [15:0] mk[13] = '{16'h3f00, 16'h3f3f, 16'h003f, 16'h3f3f, 16'h3f3f, 16'h3f3f,
	16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f00, 16'h3f00, 16'h3f3f};
// Per-register high and low selector values: each implemented field names the outs bit it feeds
reg [5:0] hv[13] = '{19, 21, 0, 16, 18, 7, 9, 11, 13, 5, 14, 1, 2};
reg [5:0] lv[13] = '{0, 20, 22, 15, 17, 6, 8, 10, 12, 4, 0, 0, 3};
ipsm_pad_model pm (.ref_clk(ref_clk), .pat(pat), .pads(pads));
ipsm_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .remap_lock_bit(lock), .remappable_io_pin(pads),
	.ext_irq_in(outs[22:19]), .timer_clk_in(outs[18:15]), .capture_in(outs[14:6]),
	.compare_fault_in(outs[5:4]), .uart1_rx_in(outs[3]), .uart1_cts_in(outs[2]),
	.uart3_rx_in(outs[1]));
assign outs[0] = 1'b0;
initial begin
	forever #5 ref_clk = ~ref_clk;
end
task summarize;
	$display("compares %0d mismatches %0d", cmp_count, err_total);
	if (err_total == 0 && cmp_count > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
task automatic apb(input bit w, input int i, input [31:0] d);
	int n;
	@(posedge ref_clk);
	psel <= 1;
	pwrite <= w;
	paddr <= {1'b0, i[4:0], 2'b00};
	pwdata <= d;
	@(posedge ref_clk);
	penable <= 1;
	n = 0;
	do begin
		@(posedge ref_clk);
		n++;
	end while (pready !== 1'b1 && n < 50);
	if (n >= 50) begin
		$display("mismatch pready exp 1 got %b", pready);
		err_total++;
		summarize;
	end
	r = prdata;
	e = pslverr;
	psel <= 0;
	penable <= 0;
endtask
// ****
// Scenarios
// ****
task t_reset;
	nrst <= 0;
	repeat (6) @(posedge ref_clk);
	nrst <= 1;
	repeat (4) @(posedge ref_clk);
	`CHK("outs", 23'h0, outs)
	for (int k = 0; k < 13; k++) begin
		apb(0, ix[k], 0);
		`CHK("reset", {16'h0, mk[k]}, r)
	end
endtask
task automatic t_route(input [5:0] s, input [43:0] p, input [21:0] x);
	for (int k = 0; k < 13; k++) begin
		apb(1, ix[k], {16'hffff, 2'b11, s, 2'b11, s});
		apb(0, ix[k], 0);
		`CHK("map", {16'h0, {2'b0, s, 2'b0, s} & mk[k]}, r)
	end
	pat <= p;
	repeat (6) @(posedge ref_clk);
	`CHK("route", x, outs[22:1])
endtask
task automatic t_walk;
	for (int k = 0; k < 13; k++) begin
		apb(1, ix[k], {16'hffff, 2'b11, hv[k], 2'b11, lv[k]});
		apb(0, ix[k], 0);
		`CHK("fld", {16'h0, {2'b0, hv[k], 2'b0, lv[k]} & mk[k]}, r)
	end
	for (int b = 1; b < 23; b++) begin
		pat <= 44'h1 << b;
		repeat (6) @(posedge ref_clk);
		`CHK("walk", 23'h1 << b, outs)
	end
endtask
task t_lock;
	lock <= 1;
	repeat (3) @(posedge ref_clk);
	apb(1, 1, 32'h0);
	`CHK("locked_err", 1'b0, e)
	apb(0, 1, 0);
	`CHK("locked", 32'h2c2c, r)
	apb(0, 31, 0);
	`CHK("status", 32'h1, r)
	apb(1, 31, 0);
	`CHK("status_wr", 1'b1, e)
	lock <= 0;
	repeat (3) @(posedge ref_clk);
	apb(1, 1, 32'h0);
	apb(0, 1, 0);
	`CHK("unlocked", 32'h0, r)
	apb(0, 5, 0);
	`CHK("unmapped", 33'h100000000, {e, r})
endtask
initial begin
	t_reset;
	t_route(6'h05, 44'h20, 22'h3fffff);
	t_route(6'h05, 44'h0, 22'h0);
	t_route(6'h2b, 44'h80000000000, 22'h3fffff);
	t_route(6'h2c, 44'hfffffffffff, 22'h0);
	t_lock;
	t_walk;
	pat <= {44{1'b1}};
	t_reset;
	summarize;
end
endmodule
